/* File: trig_gate_pkg.sv */
// shared constants and types for the trigger output gating block
package trig_gate_pkg;
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned EDGE_PULSE_NS = 5000;
	localparam int unsigned EDGE_PULSE_CYC = (EDGE_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned REACT_DELAY = 4;
	localparam logic [21:0] REDUCE_MAX = 22'h2D_C6C0;
	localparam logic [21:0] REDUCE_RST = 22'h00_0001;
	localparam logic [13:0] COUNT_STOP = 14'h0000;
	localparam logic [13:0] COUNT_CONT = 14'h3FFF;
	localparam logic [13:0] COUNT_RST = 14'h0001;
	localparam int unsigned MARK_BIT = 31;
	localparam int unsigned EVT_LSB = 16;
	localparam int unsigned STATUS_TRIG_BIT = 15;
	localparam logic [4:0] REG_MODE = 5'h00;
	localparam logic [4:0] REG_REDUCE = 5'h04;
	localparam logic [4:0] REG_COUNT = 5'h08;
	localparam logic [4:0] REG_CMD = 5'h0C;
	localparam logic [4:0] REG_STAT = 5'h10;
	localparam logic [4:0] REG_WORD = 5'h14;
	localparam logic [7:0] MODE_RST = 8'h00;
	typedef enum logic [1:0] {TRIG_NONE, TRIG_LEVEL, TRIG_EDGE, TRIG_SOFT} trig_mode_t;
endpackage

/* File: sync2.sv */
// two flip-flop synchroniser for a pin level
`timescale 1ns/1ns
`default_nettype none
module sync2 (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic d,
	output logic q
);
	logic meta_ff;
	// two stages, only the second is read
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_ff <= 1'b0;
			q <= 1'b0;
		end else begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end
endmodule // sync2
`default_nettype wire

/* File: trigger_output_gating.sv */
// trigger gating, sub-sampling and trigger marking of the measurement stream
// How it works
// - emit every nth value, n 1..3000000
// - reduction only on selected output interfaces
// - triggering never changes measurement cycle timing
// - output reacts four cycles after trigger
// - level mode outputs while level held
// - edge starts counted or continuous output
// - count 0 stop, 16383 continuous, else count; in edge mode count 0 still passes the value at each edge
// - software command starts output, no timing
// - count zero in software mode stops output
// - input high when positive above negative
// - shared input defaults to synchronisation
// - acquire only after valid trigger, except in output-all or no-trigger mode
// - averaging skips values before trigger, except in output-all or no-trigger mode
// - output-all passes everything, marks status bit 15
// - status bit 15 shows trigger present, in output-all mode only
// - no output-all on fieldbus
// - counter word only on network output
// - counter word: marker, reserved, event, value
// - word bit 31 shows trigger present
// - output-all marker high in events only
// - 14-bit event counter counts effective edges
// - value counter clears on edge, counts values
// - counter reset acts on next edge
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module trigger_output_gating (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic trig_cmp_pin,
	input wire logic meas_tick,
	input wire logic [4:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output logic acquire_ff,
	output logic serial_valid_ff,
	output logic net_valid_ff,
	output logic fieldbus_valid_ff,
	output logic status_trig_ff,
	output logic [31:0] counter_word_ff,
	output logic counter_word_en_ff,
	output logic avg_hold_ff,
	output logic sync_in_ff
);
	// mode register fields
	logic [7:0] mode_ff;
	trig_gate_pkg::trig_mode_t trig_mode;
	logic pol_high, out_all, use_trig, red_serial, red_net, fieldbus_mode, extra_cnt;
	assign trig_mode = trig_gate_pkg::trig_mode_t'(mode_ff[1:0]);
	assign pol_high = mode_ff[2];
	assign out_all = mode_ff[3];
	assign use_trig = mode_ff[4];
	assign red_serial = mode_ff[5];
	assign red_net = mode_ff[6];
	assign fieldbus_mode = mode_ff[7];
	logic extra_ff;
	assign extra_cnt = extra_ff;
	logic [21:0] reduce_ff;
	logic [13:0] count_ff;
	logic soft_pulse, cnt_rst_cmd;

	// address decode for the write path and the command strobes; the read path decodes with its own case
	function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
		hit = (a == r);
	endfunction

	// register writes; the comparator input defaults to synchronisation
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mode_ff <= trig_gate_pkg::MODE_RST;
			reduce_ff <= trig_gate_pkg::REDUCE_RST;
			count_ff <= trig_gate_pkg::COUNT_RST;
			extra_ff <= 1'b0;
		end else if (wr) begin
			if (hit(addr, trig_gate_pkg::REG_MODE))
				mode_ff <= wdata[7:0];
			if (hit(addr, trig_gate_pkg::REG_REDUCE)) begin
				if (wdata[21:0] == 22'h00_0000)
					reduce_ff <= trig_gate_pkg::REDUCE_RST;
				else if (wdata[21:0] > trig_gate_pkg::REDUCE_MAX)
					reduce_ff <= trig_gate_pkg::REDUCE_MAX;
				else
					reduce_ff <= wdata[21:0];
			end
			if (hit(addr, trig_gate_pkg::REG_COUNT))
				count_ff <= wdata[13:0];
			if (hit(addr, trig_gate_pkg::REG_CMD))
				extra_ff <= wdata[2]; // extra data select
		end
	end
	assign soft_pulse = wr && hit(addr, trig_gate_pkg::REG_CMD) && wdata[0];
	assign cnt_rst_cmd = wr && hit(addr, trig_gate_pkg::REG_CMD) && wdata[1];

	// comparator level through two flops; high means positive above negative
	logic trig_lvl;
	sync2 u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.d(trig_cmp_pin),
		.q(trig_lvl)
	);

	// shared input routed to sync path or trigger path
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			sync_in_ff <= 1'b0;
		else
			sync_in_ff <= use_trig ? 1'b0 : trig_lvl;
	end

	// sample the trigger once per measurement cycle, delay line of 4 cycles
	logic [trig_gate_pkg::REACT_DELAY-1:0] dly_ff;
	logic trig_d, prev_d;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dly_ff <= '0;
			prev_d <= 1'b0;
		end else if (meas_tick) begin
			dly_ff <= {dly_ff[trig_gate_pkg::REACT_DELAY-2:0], trig_lvl};
			prev_d <= trig_d;
		end
	end
	assign trig_d = dly_ff[trig_gate_pkg::REACT_DELAY-1];

	// active level and effective edge, mapped by polarity
	logic act_lvl, eff_edge, soft_pend_ff, soft_go, pin_edge;
	assign act_lvl = use_trig && (pol_high ? trig_d : !trig_d);
	assign pin_edge = meas_tick && act_lvl && (pol_high ? !prev_d : prev_d);
	always_comb begin
		eff_edge = 1'b0;
		soft_go = 1'b0;
		case (trig_mode)
			trig_gate_pkg::TRIG_LEVEL: eff_edge = pin_edge;
			trig_gate_pkg::TRIG_EDGE: eff_edge = pin_edge;
			trig_gate_pkg::TRIG_SOFT: begin
				soft_go = meas_tick && soft_pend_ff;
				eff_edge = soft_go && (count_ff != trig_gate_pkg::COUNT_STOP);
			end
			default: eff_edge = 1'b0;
		endcase
	end

	// pending software trigger, taken at next measurement cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			soft_pend_ff <= 1'b0;
		else if (soft_pulse)
			soft_pend_ff <= 1'b1;
		else if (meas_tick)
			soft_pend_ff <= 1'b0;
	end

	// burst state for edge and software modes
	logic [13:0] left_ff;
	logic burst_ff, cont_ff, stop_now;
	assign stop_now = (trig_mode == trig_gate_pkg::TRIG_SOFT || trig_mode == trig_gate_pkg::TRIG_EDGE)
		&& count_ff == trig_gate_pkg::COUNT_STOP;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			burst_ff <= 1'b0;
			cont_ff <= 1'b0;
			left_ff <= '0;
		end else if (stop_now || trig_mode == trig_gate_pkg::TRIG_NONE
			|| trig_mode == trig_gate_pkg::TRIG_LEVEL) begin
			burst_ff <= 1'b0;
			cont_ff <= 1'b0;
			left_ff <= '0;
		end else if (eff_edge) begin
			// the edge value is the first of the count
			burst_ff <= (count_ff != 14'h0001);
			cont_ff <= (count_ff == trig_gate_pkg::COUNT_CONT);
			left_ff <= count_ff - 14'h0001;
		end else if (meas_tick && burst_ff && !cont_ff) begin
			left_ff <= left_ff - 14'h0001;
			if (left_ff == 14'h0001)
				burst_ff <= 1'b0;
		end
	end

	// trigger present for the current value
	logic trig_on;
	always_comb begin
		case (trig_mode)
			trig_gate_pkg::TRIG_LEVEL: trig_on = act_lvl;
			trig_gate_pkg::TRIG_EDGE: trig_on = eff_edge || burst_ff;
			trig_gate_pkg::TRIG_SOFT: trig_on = eff_edge || burst_ff;
			default: trig_on = 1'b0;
		endcase
	end

	// value passes gate: all values in output-all or no-trigger mode
	logic pass, no_trig;
	assign no_trig = (trig_mode == trig_gate_pkg::TRIG_NONE);
	assign pass = no_trig || out_all || trig_on;

	// event and value counters; reset request waits for next edge
	logic [13:0] evt_ff, val_ff, nxt_evt, nxt_val;
	logic rst_pend_ff, first_ff;
	// next counts are also what the word of this value carries
	assign nxt_evt = !eff_edge ? evt_ff
		: (rst_pend_ff || cnt_rst_cmd || first_ff) ? 14'h0000
		: evt_ff + 14'h0001;
	assign nxt_val = eff_edge ? 14'h0000
		: (meas_tick && trig_on && val_ff != 14'h3FFF) ? val_ff + 14'h0001
		: val_ff;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			evt_ff <= '0;
			val_ff <= '0;
			rst_pend_ff <= 1'b0;
			first_ff <= 1'b1;
		end else begin
			evt_ff <= nxt_evt;
			val_ff <= nxt_val;
			if (eff_edge) begin
				first_ff <= 1'b0;
				rst_pend_ff <= 1'b0;
			end else if (cnt_rst_cmd)
				rst_pend_ff <= 1'b1;
		end
	end

	// modulo-n sub-sampler on gated stream
	logic [21:0] sub_ff;
	logic sub_emit;
	assign sub_emit = (sub_ff == 22'h00_0000);
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			sub_ff <= '0;
		else if (meas_tick && pass) begin
			if (sub_ff >= reduce_ff - 22'h00_0001)
				sub_ff <= '0;
			else
				sub_ff <= sub_ff + 22'h00_0001;
		end
	end

	// output strobes per interface, one per measurement cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			serial_valid_ff <= 1'b0;
			net_valid_ff <= 1'b0;
			fieldbus_valid_ff <= 1'b0;
			acquire_ff <= 1'b0;
			avg_hold_ff <= 1'b0;
		end else begin
			serial_valid_ff <= meas_tick && pass && !fieldbus_mode
				&& (!red_serial || sub_emit);
			net_valid_ff <= meas_tick && pass && !fieldbus_mode
				&& (!red_net || sub_emit);
			fieldbus_valid_ff <= meas_tick && fieldbus_mode
				&& (no_trig || trig_on);
			acquire_ff <= meas_tick && (no_trig || out_all || trig_on);
			avg_hold_ff <= meas_tick && !out_all && !no_trig
				&& !trig_on;
		end
	end

	// status marker and counter word for each value
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			status_trig_ff <= 1'b0;
			counter_word_ff <= '0;
			counter_word_en_ff <= 1'b0;
		end else if (meas_tick) begin
			status_trig_ff <= out_all && trig_on;
			counter_word_ff <= {trig_on, 1'b0, nxt_evt, 2'b00, nxt_val};
			counter_word_en_ff <= extra_cnt && !fieldbus_mode;
		end
	end

	// read port, data one cycle after strobe
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			rdata <= '0;
		else if (rd) begin
			case (addr)
				trig_gate_pkg::REG_MODE: rdata <= {24'h00_0000, mode_ff};
				trig_gate_pkg::REG_REDUCE: rdata <= {10'h000, reduce_ff};
				trig_gate_pkg::REG_COUNT: rdata <= {18'h0_0000, count_ff};
				trig_gate_pkg::REG_CMD: rdata <= {29'h0000_0000, extra_ff, rst_pend_ff, soft_pend_ff};
				trig_gate_pkg::REG_STAT: rdata <= {29'h0000_0000, burst_ff, trig_on, trig_d};
				trig_gate_pkg::REG_WORD: rdata <= counter_word_ff;
				default: rdata <= '0;
			endcase
		end else
			rdata <= '0;
	end

	// checks
	property p_delay;
		@(posedge clk) disable iff (!reset_n)
		meas_tick |=> dly_ff[0] == $past(trig_lvl);
	endproperty
	a_delay: assert property (p_delay) else $error("delay stage not loaded");
	property p_stop;
		@(posedge clk) disable iff (!reset_n)
		stop_now |=> !burst_ff;
	endproperty
	a_stop: assert property (p_stop) else $error("burst not stopped at zero count");
	property p_mark;
		@(posedge clk) disable iff (!reset_n)
		status_trig_ff |-> counter_word_ff[trig_gate_pkg::MARK_BIT];
	endproperty
	a_mark: assert property (p_mark) else $error("markers disagree");
	property p_none;
		@(posedge clk) disable iff (!reset_n)
		(meas_tick && no_trig) |=> !counter_word_ff[trig_gate_pkg::MARK_BIT];
	endproperty
	a_none: assert property (p_none) else $error("marker set without trigger mode");
	property p_val_clr;
		@(posedge clk) disable iff (!reset_n)
		eff_edge |=> val_ff == 14'h0000;
	endproperty
	a_val_clr: assert property (p_val_clr) else $error("value counter not cleared");
	property p_evt;
		@(posedge clk) disable iff (!reset_n)
		(eff_edge && !rst_pend_ff && !cnt_rst_cmd && !first_ff) |=> evt_ff == $past(evt_ff) + 14'h0001;
	endproperty
	a_evt: assert property (p_evt) else $error("event counter not advanced");
	property p_rst;
		@(posedge clk) disable iff (!reset_n)
		(cnt_rst_cmd && !eff_edge) |=> rst_pend_ff && evt_ff == $past(evt_ff);
	endproperty
	a_rst: assert property (p_rst) else $error("counter reset acted early");
	property p_fieldbus;
		@(posedge clk) disable iff (!reset_n)
		(meas_tick && fieldbus_mode) |=> !serial_valid_ff && !net_valid_ff && !counter_word_en_ff;
	endproperty
	a_fieldbus: assert property (p_fieldbus) else $error("network data in fieldbus mode");
	property p_reduce;
		@(posedge clk) disable iff (!reset_n)
		reduce_ff >= trig_gate_pkg::REDUCE_RST && reduce_ff <= trig_gate_pkg::REDUCE_MAX;
	endproperty
	a_reduce: assert property (p_reduce) else $error("reduction factor out of range");
endmodule // trigger_output_gating
`default_nettype wire

/* File: trig_model.sv */
// partner model: trigger source on the comparator pin and output consumer
`timescale 1ns/1ns
`default_nettype none
module trig_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic want_level,
	input wire logic clr,
	input wire logic serial_valid,
	input wire logic net_valid,
	input wire logic marker,
	output logic trig_cmp_pin,
	output logic [15:0] n_ser,
	output logic [15:0] n_net,
	output logic [15:0] n_mark
);
	logic [7:0] held_ff;
	// comparator level, each level stands at least one edge pulse time
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			trig_cmp_pin <= 1'b0;
			held_ff <= 8'h00;
		end else if (want_level != trig_cmp_pin && 32'(held_ff) >= trig_gate_pkg::EDGE_PULSE_CYC) begin
			trig_cmp_pin <= want_level;
			held_ff <= 8'h00;
		end else if (held_ff != 8'hff) begin
			held_ff <= held_ff + 8'h01;
		end
	end
	// consumer: counts emitted values and marked values
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			n_ser <= 16'h0000;
			n_net <= 16'h0000;
			n_mark <= 16'h0000;
		end else if (clr) begin
			n_ser <= 16'h0000;
			n_net <= 16'h0000;
			n_mark <= 16'h0000;
		end else begin
			n_ser <= n_ser + 16'(serial_valid);
			n_net <= n_net + 16'(net_valid);
			n_mark <= n_mark + 16'(net_valid && marker);
		end
	end
endmodule // trig_model
`default_nettype wire

/* File: testbench.sv */
// self-checking testbench for the trigger output gating block
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clk, reset_n, meas_tick, wr, rd, want_level, clr, trig_cmp_pin;
	logic [4:0] addr;
	logic [31:0] wdata, rdata, counter_word_ff;
	logic acquire_ff, serial_valid_ff, net_valid_ff, fieldbus_valid_ff, status_trig_ff;
	logic counter_word_en_ff, avg_hold_ff, sync_in_ff;
	logic [15:0] n_ser, n_net, n_mark;
	logic [3:0] tcnt;
	int n_mismatch, checks_done;
	int n_fb, n_acq, n_hold;
	trigger_output_gating trigger_output_gating_inst (.clk(clk), .reset_n(reset_n),
		.trig_cmp_pin(trig_cmp_pin), .meas_tick(meas_tick), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .acquire_ff(acquire_ff),
		.serial_valid_ff(serial_valid_ff), .net_valid_ff(net_valid_ff),
		.fieldbus_valid_ff(fieldbus_valid_ff), .status_trig_ff(status_trig_ff),
		.counter_word_ff(counter_word_ff), .counter_word_en_ff(counter_word_en_ff),
		.avg_hold_ff(avg_hold_ff), .sync_in_ff(sync_in_ff));
	trig_model trig_model_inst (.clk(clk), .reset_n(reset_n), .want_level(want_level),
		.clr(clr), .serial_valid(serial_valid_ff), .net_valid(net_valid_ff),
		.marker(status_trig_ff), .trig_cmp_pin(trig_cmp_pin), .n_ser(n_ser), .n_net(n_net),
		.n_mark(n_mark));
	// 100 ns clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// measurement cycle every ten clocks
	always @(posedge clk) begin
		tcnt <= (tcnt == 4'h9) ? 4'h0 : tcnt + 4'h1;
		meas_tick <= (tcnt == 4'h9);
	end
	// counts of output pulses the model does not watch
	always @(posedge clk) begin
		if (clr) begin
			n_fb <= 0;
			n_acq <= 0;
			n_hold <= 0;
		end else begin
			n_fb <= n_fb + int'(fieldbus_valid_ff);
			n_acq <= n_acq + int'(acquire_ff);
			n_hold <= n_hold + int'(avg_hold_ff);
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [4:0] a, input logic [31:0] exp, input string what);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, exp, what);
	endtask
	task automatic ticks(input int n);
		repeat (n * 10) @(posedge clk);
		#1; // look after the last edge's updates
	endtask
	task automatic pulse(input int n);
		want_level <= 1'b1;
		ticks(n);
		want_level <= 1'b0;
	endtask
	task automatic clear;
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		{reset_n, wr, rd, want_level, clr, meas_tick} = 6'b000000;
		addr = 5'h00;
		wdata = 32'h0000_0000;
		tcnt = 4'h0;
		n_mismatch = 0;
		checks_done = 0;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		rd_reg(trig_gate_pkg::REG_MODE, 32'h0000_0000, "mode reset");
		rd_reg(trig_gate_pkg::REG_COUNT, 32'h0000_0001, "count reset");
		rd_reg(5'h1c, 32'h0000_0000, "unmapped");
		wr_reg(trig_gate_pkg::REG_REDUCE, 32'h002d_c6c1);
		rd_reg(trig_gate_pkg::REG_REDUCE, 32'h002d_c6c0, "reduce clamp");
		wr_reg(trig_gate_pkg::REG_REDUCE, 32'h0000_0003);
		wr_reg(trig_gate_pkg::REG_MODE, 32'h0000_0020);
		clear;
		ticks(9);
		chk(32'(n_ser), 32'h0000_0003, "reduced serial");
		chk(32'(n_net), 32'h0000_0009, "unreduced net");
		chk(32'(n_mark), 32'h0000_0000, "no marker");
		chk(n_acq, 32'h0000_0009, "acquire all");
		chk(n_hold, 32'h0000_0000, "no held averages");
		$display("test reduction done");
		wr_reg(trig_gate_pkg::REG_REDUCE, 32'h0000_0001);
		wr_reg(trig_gate_pkg::REG_MODE, 32'h0000_0015);
		clear;
		pulse(6);
		chk(32'(sync_in_ff), 32'h0000_0000, "input to trigger");
		ticks(10);
		chk(32'(n_net), 32'h0000_0006, "level values");
		chk(n_acq, 32'h0000_0006, "acquired values");
		chk(n_hold, 32'h0000_000a, "held averages");
		$display("test level done");
		wr_reg(trig_gate_pkg::REG_COUNT, 32'h0000_0003);
		wr_reg(trig_gate_pkg::REG_MODE, 32'h0000_0016);
		clear;
		pulse(7);
		ticks(10);
		chk(32'(n_net), 32'h0000_0003, "edge values");
		chk(32'(counter_word_ff[29:16]), 32'h0000_0001, "event count");
		wr_reg(trig_gate_pkg::REG_CMD, 32'h0000_0002);
		rd_reg(trig_gate_pkg::REG_WORD, 32'h0001_0002, "count kept");
		pulse(7);
		ticks(10);
		chk(32'(counter_word_ff[29:16]), 32'h0000_0000, "event cleared");
		$display("test edge done");
		wr_reg(trig_gate_pkg::REG_MODE, 32'h0000_0003);
		wr_reg(trig_gate_pkg::REG_COUNT, 32'h0000_0002);
		clear;
		wr_reg(trig_gate_pkg::REG_CMD, 32'h0000_0001);
		ticks(10);
		chk(32'(n_net), 32'h0000_0002, "soft values");
		wr_reg(trig_gate_pkg::REG_COUNT, 32'h0000_3fff);
		wr_reg(trig_gate_pkg::REG_CMD, 32'h0000_0001);
		ticks(8);
		clear;
		ticks(6);
		chk(32'(n_net), 32'h0000_0006, "continuous");
		wr_reg(trig_gate_pkg::REG_COUNT, 32'h0000_0000);
		ticks(7);
		clear;
		ticks(8);
		chk(32'(n_net), 32'h0000_0000, "soft stop");
		$display("test software done");
		wr_reg(trig_gate_pkg::REG_MODE, 32'h0000_001d);
		wr_reg(trig_gate_pkg::REG_CMD, 32'h0000_0004);
		clear;
		ticks(6);
		chk(32'(counter_word_en_ff), 32'h0000_0001, "word enable");
		pulse(6);
		ticks(6);
		chk(32'(n_net), 32'h0000_0012, "all values");
		chk(32'(n_mark), 32'h0000_0006, "marked values");
		$display("test output all done");
		wr_reg(trig_gate_pkg::REG_MODE, 32'h0000_0011);
		clear;
		pulse(6);
		ticks(10);
		chk(32'(n_net), 32'h0000_000a, "low level values");
		chk(n_hold, 32'h0000_0006, "low level holds");
		$display("test low level done");
		wr_reg(trig_gate_pkg::REG_MODE, 32'h0000_0080);
		clear;
		ticks(5);
		chk(n_fb, 32'h0000_0005, "fieldbus values");
		chk(32'(n_net), 32'h0000_0000, "no network values");
		chk(32'(n_ser), 32'h0000_0000, "no serial values");
		$display("test fieldbus done");
		finish_test;
	end
endmodule // testbench
`default_nettype wire
